// [design/tqh_map.svh]
// register offsets, field positions and reset values of the queue register bank
`ifndef TQH_MAP_SVH
`define TQH_MAP_SVH

// printed offsets are word addresses: kept as indices, byte address is index * 4
`define TQH_IDX_TX_SPACE_REQ   8'h9E
`define TQH_IDX_HASH_W0        8'hA0
`define TQH_IDX_HASH_W1        8'hA2
`define TQH_IDX_HASH_W2        8'hA4
`define TQH_IDX_HASH_W3        8'hA6
`define TQH_IDX_RX_LOW_WM      8'hB0
`define TQH_IDX_RX_HIGH_WM     8'hB2
`define TQH_IDX_RX_OVR_WM      8'hB4
`define TQH_IDX_CTRL           8'hB8
`define TQH_IDX_INT_STATUS     8'hBA
`define TQH_IDX_INT_MASK       8'hBC
`define TQH_IDX_QSTATUS        8'hBE

`define TQH_CTRL_TX_MON_BIT    1
`define TQH_CTRL_RX_ALL_BIT    4
`define TQH_CTRL_RX_MCAST_BIT  5
`define TQH_CTRL_HASH_MODE_BIT 8
`define TQH_INT_TX_SPACE_BIT   6
`define TQH_INT_OVERRUN_BIT    0

`define TQH_RST_TX_SPACE_REQ   16'h0000
`define TQH_RST_HASH           16'h0000
`define TQH_RST_RX_LOW_WM      12'h500
`define TQH_RST_RX_HIGH_WM     12'h300
`define TQH_RST_RX_OVR_WM      12'h040
`define TQH_WM_BITS            12

`endif

// [design/tqh_pkg.sv]
// types shared by the queue register bank
package tqh_pkg;
   typedef struct packed {
      logic        valid;
      logic [5:0]  hash_idx;
      logic        is_mcast;
   } tqh_rx_frame_t;

   typedef struct packed {
      logic        accept;
      logic        drop;
   } tqh_filter_res_t;
endpackage

// [design/tqh_hash_filter.sv]
// multicast hash table lookup for received frames
`timescale 1ns/1ps
`default_nettype none
`include "tqh_map.svh"
module tqh_hash_filter
   import tqh_pkg::*;
(
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic [63:0]     table_bits,
   input  wire logic            hash_mode,
   input  wire logic            rx_all,
   input  wire logic            rx_mcast,
   input  wire tqh_rx_frame_t   frame,
   output var  tqh_filter_res_t result_q
);
   // =========================================
   // lookup
   // upper two index bits pick the word, lower four the bit
   wire logic [1:0] word_sel = frame.hash_idx[5:4];
   wire logic [3:0] bit_sel  = frame.hash_idx[3:0];
   wire logic       tbl_hit  = table_bits[{word_sel, bit_sel}];
   // promiscuous enables override the table
   wire logic       pass_all = rx_all | rx_mcast;
   // table only consulted in hash mode; otherwise every multicast frame is accepted
   wire logic       keep     = !frame.is_mcast || !hash_mode || pass_all || tbl_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_q <= '0;
      end else begin
         result_q.accept <= frame.valid & keep;
         result_q.drop   <= frame.valid & !keep;
      end
   end
endmodule // tqh_hash_filter
`default_nettype wire

// [design/tqh_queue_regs.sv]
// top: tx space request, multicast hash table and rx watermarks over apb
// =========================================
// What this block does
// - monitor set: interrupt when space suffices
// - space flag sticky, host writes one to clear
// - 64-bit hash table, used in hash mode
// - index is six top crc bits
// - top two bits word, four bits position
// - set bit accepts frame, clear bit drops
// - receive-all or multicast enable accepts all multicast
// - low watermark 12 bits, reset 0x0500
// - high watermark 12 bits, reset 0x0300
// - overrun watermark 12 bits, reset 0x0040
// - watermark bits 15..12 reserved, read zero
`timescale 1ns/1ps
`default_nettype none
`include "tqh_map.svh"
module tqh_queue_regs
   import tqh_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output var  logic [31:0]   prdata,
   output var  logic          pready,
   output var  logic          pslverr,
   input  wire logic [15:0]   tx_free_dwords,
   input  wire logic [11:0]   rx_avail_dwords,
   input  wire logic          rx_frame_valid,
   input  wire logic [31:0]   rx_da_crc,
   input  wire logic          rx_da_is_mcast,
   output var  logic          rx_accept_q,
   output var  logic          rx_drop_q,
   output var  logic          flow_pause_q,
   output var  logic          irq_q
);
   // =========================================
   // address decode
   wire logic        acc      = psel & penable;
   wire logic [9:0]  word     = paddr[11:2];
   wire logic        wr_en    = acc & pwrite & pready;
   wire logic        lo_we    = wr_en & pstrb[0];
   wire logic        hi_we    = wr_en & pstrb[1];
   wire logic        hit_req  = word == 10'(`TQH_IDX_TX_SPACE_REQ);
   wire logic        hit_h0   = word == 10'(`TQH_IDX_HASH_W0);
   wire logic        hit_h1   = word == 10'(`TQH_IDX_HASH_W1);
   wire logic        hit_h2   = word == 10'(`TQH_IDX_HASH_W2);
   wire logic        hit_h3   = word == 10'(`TQH_IDX_HASH_W3);
   wire logic        hit_lw   = word == 10'(`TQH_IDX_RX_LOW_WM);
   wire logic        hit_hw   = word == 10'(`TQH_IDX_RX_HIGH_WM);
   wire logic        hit_ow   = word == 10'(`TQH_IDX_RX_OVR_WM);
   wire logic        hit_ctl  = word == 10'(`TQH_IDX_CTRL);
   wire logic        hit_ist  = word == 10'(`TQH_IDX_INT_STATUS);
   wire logic        hit_imk  = word == 10'(`TQH_IDX_INT_MASK);
   wire logic        hit_qst  = word == 10'(`TQH_IDX_QSTATUS);
   wire logic        hit_any  = hit_req | hit_h0 | hit_h1 | hit_h2 | hit_h3 | hit_lw | hit_hw
                                | hit_ow | hit_ctl | hit_ist | hit_imk | hit_qst;

   // =========================================
   // registers
   logic [15:0] space_req_q;
   logic [15:0] hash_q [4];
   logic [11:0] low_wm_q;
   logic [11:0] high_wm_q;
   logic [11:0] ovr_wm_q;
   logic [15:0] ctrl_q;
   logic [15:0] int_status_q;
   logic [15:0] int_mask_q;

   // merge a halfword write under byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic lo, input logic hi);
      merge16 = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
   endfunction

   wire logic [15:0] wd = pwdata[15:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         space_req_q <= `TQH_RST_TX_SPACE_REQ;
         ctrl_q      <= 16'h0000;
         int_mask_q  <= 16'h0000;
      end else begin
         if (hit_req) space_req_q <= merge16(space_req_q, wd, lo_we, hi_we);
         if (hit_ctl) ctrl_q      <= merge16(ctrl_q, wd, lo_we, hi_we);
         if (hit_imk) int_mask_q  <= merge16(int_mask_q, wd, lo_we, hi_we);
      end
   end

   // four hash words, one per index bank
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_hash
         wire logic hit_w = word == 10'(`TQH_IDX_HASH_W0 + 2 * gi);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hash_q[gi] <= `TQH_RST_HASH;
            end else if (hit_w) begin
               hash_q[gi] <= merge16(hash_q[gi], wd, lo_we, hi_we);
            end
         end
      end
   endgenerate

   // reserved top nibble is never stored
   wire logic [15:0] wm_lw = merge16({4'h0, low_wm_q}, wd, lo_we, hi_we);
   wire logic [15:0] wm_hw = merge16({4'h0, high_wm_q}, wd, lo_we, hi_we);
   wire logic [15:0] wm_ow = merge16({4'h0, ovr_wm_q}, wd, lo_we, hi_we);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_wm_q  <= `TQH_RST_RX_LOW_WM;
         high_wm_q <= `TQH_RST_RX_HIGH_WM;
         ovr_wm_q  <= `TQH_RST_RX_OVR_WM;
      end else begin
         if (hit_lw) low_wm_q  <= wm_lw[`TQH_WM_BITS-1:0];
         if (hit_hw) high_wm_q <= wm_hw[`TQH_WM_BITS-1:0];
         if (hit_ow) ovr_wm_q  <= wm_ow[`TQH_WM_BITS-1:0];
      end
   end

   // =========================================
   // tx space monitor
   wire logic tx_mon     = ctrl_q[`TQH_CTRL_TX_MON_BIT];
   wire logic space_ok   = tx_free_dwords >= space_req_q;
   logic      space_ok_q;
   // edge so a flag cleared while space stays free is not re-raised every cycle
   wire logic space_evt  = tx_mon & space_ok & !space_ok_q;
   wire logic ovr_now    = rx_avail_dwords < ovr_wm_q;
   logic      ovr_q;
   wire logic ovr_evt    = ovr_now & !ovr_q;

   wire logic [15:0] set_v  = 16'((space_evt ? 16'h0001 << `TQH_INT_TX_SPACE_BIT : 16'h0000)
                              | (ovr_evt ? 16'h0001 << `TQH_INT_OVERRUN_BIT : 16'h0000));
   wire logic [15:0] clr_v  = (hit_ist & wr_en) ? merge16(16'h0000, wd, pstrb[0], pstrb[1])
                                                : 16'h0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_q <= 16'h0000;
         space_ok_q   <= 1'b0;
         ovr_q        <= 1'b0;
         irq_q        <= 1'b0;
      end else begin
         // set beats a write-one-clear in the same cycle
         int_status_q <= (int_status_q & ~clr_v) | set_v;
         space_ok_q   <= tx_mon & space_ok;
         ovr_q        <= ovr_now;
         irq_q        <= |(((int_status_q & ~clr_v) | set_v) & int_mask_q);
      end
   end

   // =========================================
   // rx flow control with hysteresis
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flow_pause_q <= 1'b0;
      end else if (rx_avail_dwords < high_wm_q) begin
         flow_pause_q <= 1'b1;
      end else if (rx_avail_dwords > low_wm_q) begin
         flow_pause_q <= 1'b0;
      end
   end

   // =========================================
   // multicast filter
   tqh_rx_frame_t   frame;
   tqh_filter_res_t res;
   assign frame.valid    = rx_frame_valid;
   assign frame.hash_idx = rx_da_crc[31:26];
   assign frame.is_mcast = rx_da_is_mcast;

   tqh_hash_filter u_filter (
      .pclk       (pclk),
      .presetn    (presetn),
      .table_bits ({hash_q[3], hash_q[2], hash_q[1], hash_q[0]}),
      .hash_mode  (ctrl_q[`TQH_CTRL_HASH_MODE_BIT]),
      .rx_all     (ctrl_q[`TQH_CTRL_RX_ALL_BIT]),
      .rx_mcast   (ctrl_q[`TQH_CTRL_RX_MCAST_BIT]),
      .frame      (frame),
      .result_q   (res)
   );
   assign rx_accept_q = res.accept;
   assign rx_drop_q   = res.drop;

   // =========================================
   // read mux and apb answer
   wire logic [15:0] qstat = {14'h0000, flow_pause_q, ovr_now};
   wire logic [15:0] rd_mux =
        hit_req ? space_req_q :
        hit_h0  ? hash_q[0] :
        hit_h1  ? hash_q[1] :
        hit_h2  ? hash_q[2] :
        hit_h3  ? hash_q[3] :
        hit_lw  ? {4'h0, low_wm_q} :
        hit_hw  ? {4'h0, high_wm_q} :
        hit_ow  ? {4'h0, ovr_wm_q} :
        hit_ctl ? ctrl_q :
        hit_ist ? int_status_q :
        hit_imk ? int_mask_q :
        hit_qst ? qstat : 16'h0000;

   // no wait states: ready registered from the setup phase, so outputs stay flopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & !penable;
         prdata  <= (psel & !penable & !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
         pslverr <= psel & !penable & !hit_any;
      end
   end
endmodule // tqh_queue_regs
`default_nettype wire

// [verif/tqh_queue_regs_sva.sv]
// port checker for the queue register bank
`timescale 1ns/1ps
`default_nettype none
module tqh_queue_regs_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] tx_free_dwords,
   input wire logic [11:0] rx_avail_dwords,
   input wire logic        rx_frame_valid,
   input wire logic [31:0] rx_da_crc,
   input wire logic        rx_da_is_mcast,
   input wire logic        rx_accept_q,
   input wire logic        rx_drop_q,
   input wire logic        flow_pause_q,
   input wire logic        irq_q
);
   // =========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wr_go;
   wire logic is_wm;
   assign wr_go = psel & penable & pwrite & pready;
   assign is_wm = paddr == 12'h2C0 || paddr == 12'h2C8 || paddr == 12'h2D0;
   // thresholds may move only through a write
   sequence quiet;
      $stable(rx_avail_dwords) && !wr_go;
   endsequence
   a_ready_once: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_filter_once: assert property (rx_frame_valid |=> rx_accept_q != rx_drop_q)
      else $error("frame verdict missing");
   a_unicast_pass: assert property (rx_frame_valid && !rx_da_is_mcast |=> rx_accept_q)
      else $error("unicast frame dropped");
   // a mask write lands one edge before irq sees it, so skip the cycle after a write too
   a_irq_sticky: assert property (irq_q && !wr_go && !$past(wr_go) |=> irq_q)
      else $error("irq fell without a write");
   a_rsvd_zero: assert property (pready && !pwrite && !pslverr |-> prdata[31:16] == 16'h0000)
      else $error("upper half not zero");
   a_wm_rsvd: assert property (pready && !pwrite && is_wm |-> prdata[15:12] == 4'h0)
      else $error("watermark top bits set");
   a_pause_hold: assert property (quiet ##1 quiet |=> $stable(flow_pause_q))
      else $error("pause moved while quiet");
endmodule // tqh_queue_regs_sva
bind tqh_queue_regs tqh_queue_regs_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_free_dwords, .rx_avail_dwords,
   .rx_frame_valid, .rx_da_crc, .rx_da_is_mcast, .rx_accept_q, .rx_drop_q, .flow_pause_q,
   .irq_q);
`default_nettype wire

// [verif/tqh_queue_model.sv]
// queue-side model: free space levels and received frame strobes
`timescale 1ns/1ps
`default_nettype none
module tqh_queue_model (
   input  wire logic        pclk,
   input  wire logic        rx_accept_q,
   output var  logic [15:0] tx_free_dwords,
   output var  logic [11:0] rx_avail_dwords,
   output var  logic        rx_frame_valid,
   output var  logic [31:0] rx_da_crc,
   output var  logic        rx_da_is_mcast
);
   // =========================================
   // stimulus
   initial begin
      tx_free_dwords = 16'h0000;
      rx_avail_dwords = 12'hFFF;
      rx_frame_valid = 1'b0;
      rx_da_crc = 32'h0000_0000;
      rx_da_is_mcast = 1'b0;
   end
   task automatic lv(input logic [15:0] tx, input logic [11:0] rx);
      @(posedge pclk);
      tx_free_dwords <= tx;
      rx_avail_dwords <= rx;
   endtask
   // crc inverted after the strobe so a stale value is never read
   task automatic frame(input logic [5:0] idx, input logic mc, output logic acc);
      @(posedge pclk);
      rx_frame_valid <= 1'b1;
      rx_da_crc <= {idx, 26'h0AB5};
      rx_da_is_mcast <= mc;
      @(posedge pclk);
      rx_frame_valid <= 1'b0;
      rx_da_crc <= ~rx_da_crc;
      #1 acc = rx_accept_q;
   endtask
endmodule // tqh_queue_model
`default_nettype wire

// [verif/tqh_queue_regs_bench.sv]
// self-checking bench for the queue register bank
`timescale 1ns/1ps
`default_nettype none
`include "tqh_map.svh"
module tqh_queue_regs_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, acc, err;
   logic        rx_frame_valid, rx_da_is_mcast, rx_accept_q, rx_drop_q, flow_pause_q, irq_q;
   logic [11:0] paddr, rx_avail_dwords;
   logic [31:0] pwdata, prdata, rx_da_crc, rd;
   logic [3:0]  pstrb;
   logic [15:0] tx_free_dwords;
   int          mismatches, cmp_count;
   tqh_queue_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .tx_free_dwords, .rx_avail_dwords, .rx_frame_valid,
      .rx_da_crc, .rx_da_is_mcast, .rx_accept_q, .rx_drop_q, .flow_pause_q, .irq_q);
   tqh_queue_model m (.pclk, .rx_accept_q, .tx_free_dwords, .rx_avail_dwords,
      .rx_frame_valid, .rx_da_crc, .rx_da_is_mcast);
   always #2 pclk = ~pclk;
   // =========================================
   // helpers
   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // =========================================
   // scenarios
   task automatic t_reset();
      rchk(ba(`TQH_IDX_TX_SPACE_REQ), 32'h0000);
      rchk(ba(`TQH_IDX_HASH_W3), 32'h0000);
      rchk(ba(`TQH_IDX_RX_LOW_WM), 32'h0500);
      rchk(ba(`TQH_IDX_RX_HIGH_WM), 32'h0300);
      rchk(ba(`TQH_IDX_RX_OVR_WM), 32'h0040);
      $display("reset test done");
   endtask
   task automatic t_regs();
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ba(8'hB0 + 8'(2 * i)), 32'hFFFF_FFFF);
         rchk(ba(8'hB0 + 8'(2 * i)), 32'h0000_0FFF);
         apb(1'b1, ba(8'hA0 + 8'(2 * i)), 32'h1234_5A00 + 32'(i));
         rchk(ba(8'hA0 + 8'(2 * i)), 32'h5A00 + 32'(i));
      end
      apb(1'b1, ba(`TQH_IDX_TX_SPACE_REQ), 32'h0000_ABCD);
      rchk(ba(`TQH_IDX_TX_SPACE_REQ), 32'h0000_ABCD);
      // low byte lane only: upper byte must keep its old value
      pstrb <= 4'h1;
      apb(1'b1, ba(`TQH_IDX_TX_SPACE_REQ), 32'h0000_1234);
      pstrb <= 4'hF;
      rchk(ba(`TQH_IDX_TX_SPACE_REQ), 32'h0000_AB34);
      rchk(12'h004, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("register test done");
   endtask
   task automatic t_hash();
      for (int i = 0; i < 4; i++) apb(1'b1, ba(8'hA0 + 8'(2 * i)), 32'h0);
      apb(1'b1, ba(`TQH_IDX_HASH_W2), 32'h0000_0020);
      apb(1'b1, ba(`TQH_IDX_CTRL), 32'h0100);
      m.frame(6'h25, 1'b1, acc);
      chk({31'h0, acc}, 32'h1);
      m.frame(6'h15, 1'b1, acc);
      chk({31'h0, acc}, 32'h0);
      chk({31'h0, rx_drop_q}, 32'h1);
      m.frame(6'h24, 1'b0, acc);
      chk({31'h0, acc}, 32'h1);
      m.frame(6'h24, 1'b1, acc);
      chk({31'h0, acc}, 32'h0);
      apb(1'b1, ba(`TQH_IDX_CTRL), 32'h0110);
      m.frame(6'h24, 1'b1, acc);
      chk({31'h0, acc}, 32'h1);
      apb(1'b1, ba(`TQH_IDX_CTRL), 32'h0120);
      m.frame(6'h24, 1'b1, acc);
      chk({31'h0, acc}, 32'h1);
      apb(1'b1, ba(`TQH_IDX_CTRL), 32'h0000);
      m.frame(6'h24, 1'b1, acc);
      chk({31'h0, acc}, 32'h1);
      $display("hash test done");
   endtask
   task automatic t_flow();
      apb(1'b1, ba(`TQH_IDX_RX_LOW_WM), 32'h0500);
      apb(1'b1, ba(`TQH_IDX_RX_HIGH_WM), 32'h0300);
      apb(1'b1, ba(`TQH_IDX_RX_OVR_WM), 32'h0040);
      m.lv(16'h0, 12'h2FF);
      settle();
      chk({31'h0, flow_pause_q}, 32'h1);
      m.lv(16'h0, 12'h500);
      settle();
      chk({31'h0, flow_pause_q}, 32'h1);
      m.lv(16'h0, 12'h501);
      settle();
      chk({31'h0, flow_pause_q}, 32'h0);
      m.lv(16'h0, 12'h03F);
      rchk(ba(`TQH_IDX_INT_STATUS), 32'h0001);
      rchk(ba(`TQH_IDX_QSTATUS), 32'h0003);
      apb(1'b1, ba(`TQH_IDX_INT_STATUS), 32'h0001);
      m.lv(16'h0, 12'hFFF);
      $display("flow test done");
   endtask
   task automatic t_irq();
      m.lv(16'h00FF, 12'hFFF);
      apb(1'b1, ba(`TQH_IDX_TX_SPACE_REQ), 32'h0100);
      apb(1'b1, ba(`TQH_IDX_INT_MASK), 32'h0040);
      apb(1'b1, ba(`TQH_IDX_CTRL), 32'h0002);
      rchk(ba(`TQH_IDX_INT_STATUS), 32'h0000);
      m.lv(16'h0100, 12'hFFF);
      settle();
      chk({31'h0, irq_q}, 32'h1);
      rchk(ba(`TQH_IDX_INT_STATUS), 32'h0040);
      apb(1'b1, ba(`TQH_IDX_INT_MASK), 32'h0000);
      settle();
      chk({31'h0, irq_q}, 32'h0);
      apb(1'b1, ba(`TQH_IDX_INT_STATUS), 32'h0040);
      rchk(ba(`TQH_IDX_INT_STATUS), 32'h0000);
      $display("interrupt test done");
   endtask
   // =========================================
   // main sequence and watchdog
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      mismatches = 0;
      cmp_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_hash();
      t_flow();
      t_irq();
      close_out();
   end
   // whole run is about two hundred cycles
   initial begin
      #100000;
      mismatches++;
      close_out();
   end
endmodule // tqh_queue_regs_bench
`default_nettype wire
